// ===== core/ahi_pkg.sv
// Shared constants and types of the converter host interface.
package ahi_pkg;

  localparam int RES_W   = 12;
  localparam int CTRL_W  = 6;
  localparam int FRAME_W = 16;
  localparam int LINES_W = 12;

  // Shared line indices used in serial mode.
  localparam int LINE_TEST0 = 0;
  localparam int LINE_TEST1 = 1;
  localparam int LINE_TFS   = 2;
  localparam int LINE_RFS   = 3;
  localparam int LINE_DIN   = 4;
  localparam int LINE_SCLK  = 5;
  localparam int LINE_DOUT  = 6;

  // Parallel write field positions on the shared lines.
  localparam int LINE_CHAN_MSB = 6;
  localparam int LINE_CHAN_MID = 7;
  localparam int LINE_CHAN_LSB = 8;
  localparam int LINE_SOFT_CONVERT_BIT   = 9;
  localparam int LINE_STBY     = 10;
  localparam int LINE_FORMAT   = 11;

  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [3:0] CHAN_BASE  = 4'h1;

  // Settling pulse after a control write; the length is a plain default.
  localparam int SETTLE_NS  = 400;
  localparam int CLK_MHZ    = 25;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic chan_sel_msb;
    logic chan_sel_mid;
    logic chan_sel_lsb;
    logic soft_convert_bit;
    logic soft_standby_bit;
    logic format;
  } ahi_ctrl_t;

endpackage

// ===== core/ahi_serial_link.sv
// Serial link logic running on the host supplied serial clock.
`timescale 1ns/100ps
`default_nettype none
module ahi_serial_link (
  input  wire logic                            link_clk_in,
  input  wire logic                            reset_in,
  input  wire logic                            tx_frame_sync_n_in,
  input  wire logic                            rx_frame_sync_n_in,
  input  wire logic                            serial_din_in,
  input  wire logic [ahi_pkg::FRAME_W-1:0]     frame_in,
  output ahi_pkg::ahi_ctrl_t                   rx_word_out,
  output logic                                 rx_toggle_out,
  output logic                                 serial_dout_out
);

  logic [2:0] rx_cnt_q;
  logic [4:0] rx_shift_q;
  logic [4:0] tx_cnt_q;

  // The frame syncs clear the counters, so no edge outside a frame is needed.
  always_ff @(negedge link_clk_in or posedge tx_frame_sync_n_in) begin
    if (tx_frame_sync_n_in) begin
      rx_cnt_q <= 3'h0;
    end else if (rx_cnt_q < 3'(ahi_pkg::CTRL_W)) begin
      rx_cnt_q <= rx_cnt_q + 3'h1;
    end
  end

  always_ff @(negedge link_clk_in) begin
    if (!tx_frame_sync_n_in && rx_cnt_q < 3'(ahi_pkg::CTRL_W)) begin
      rx_shift_q <= {rx_shift_q[3:0], serial_din_in};
    end
  end

  // The word stays put until the next complete frame, so the toggle
  // alone can carry it into the system clock domain.
  always_ff @(negedge link_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_toggle_out <= 1'b0;
    end else if (!tx_frame_sync_n_in && rx_cnt_q == 3'(ahi_pkg::CTRL_W - 1)) begin
      rx_toggle_out <= ~rx_toggle_out;
    end
  end

  always_ff @(negedge link_clk_in) begin
    if (!tx_frame_sync_n_in && rx_cnt_q == 3'(ahi_pkg::CTRL_W - 1)) begin
      rx_word_out <= {rx_shift_q, serial_din_in};
    end
  end

  always_ff @(negedge link_clk_in or posedge rx_frame_sync_n_in) begin
    if (rx_frame_sync_n_in) begin
      tx_cnt_q <= 5'h00;
    end else if (tx_cnt_q < 5'(ahi_pkg::FRAME_W)) begin
      tx_cnt_q <= tx_cnt_q + 5'h01;
    end
  end

  always_comb begin
    serial_dout_out = 1'b0;
    if (tx_cnt_q < 5'(ahi_pkg::FRAME_W)) begin
      serial_dout_out = frame_in[4'hF - tx_cnt_q[3:0]];
    end
  end

  rx_ignore_rest_a: assert property (@(negedge link_clk_in) disable iff (reset_in)
    (!tx_frame_sync_n_in && rx_cnt_q == 3'h6) |=> $stable(rx_word_out))
    else $error("control word changed after six bits");

  tx_count_cap_a: assert property (@(negedge link_clk_in) disable iff (reset_in)
    tx_cnt_q <= 5'h10)
    else $error("serial output count ran past sixteen");

  first_bit_a: assert property (@(negedge link_clk_in) disable iff (reset_in)
    (!rx_frame_sync_n_in && tx_cnt_q == 5'h00) |-> serial_dout_out == frame_in[15])
    else $error("first serial bit is not the format bit");

endmodule
`default_nettype wire

// ===== core/ahi_host_interface.sv
// Host interface of the eight channel converter: parallel and serial modes.
//
// Behaviour
// - Mode high: reads return result on lines.
// - Parallel writes take lines as inputs.
// - Result LSB on line 0, MSB line 11.
// - Drive lines only with chip select, read low; serial mode drives line 6 always.
// - Format bit picks twos complement or binary.
// - Parallel write loads six control bits.
// - Mode low: five lines become serial link.
// - Frame: format, three address bits, result.
// - Sixteen output bits valid at falling edges.
// - Serial result coding follows format bit.
// - First six falling edges load control word.
// - Further serial input bits ignored.
// - Control word resets to zero.
// - Short transmit frame: keep word, maybe convert.
// - Channel is address plus one.
// - Write end starts settling, then convert; here only when the soft convert bit is set.
`timescale 1ns/100ps
`default_nettype none
module ahi_host_interface #(
  parameter int SETTLE_CYCLES = ahi_pkg::SETTLE_CYC
) (
  input  wire logic                              clk_in,
  input  wire logic                              reset_in,
  input  wire logic                              mode_sel_in,
  input  wire logic                              chip_sel_n_in,
  input  wire logic                              read_n_in,
  input  wire logic                              write_n_in,
  input  wire logic                              link_clk_in,
  input  wire logic [ahi_pkg::LINES_W-1:0]       shared_data_lines_in,
  output logic      [ahi_pkg::LINES_W-1:0]       shared_data_lines_out,
  output logic      [ahi_pkg::LINES_W-1:0]       shared_data_lines_oe_out,
  input  wire logic [ahi_pkg::RES_W-1:0]         result_in,
  output logic                                   convert_start_out,
  output logic                                   standby_out,
  output logic      [3:0]                        channel_out,
  output ahi_pkg::ahi_ctrl_t                     control_word_out
);

  localparam int SYNC_W   = ahi_pkg::LINES_W + 4;
  localparam logic [3:0] CHAN_INIT = ahi_pkg::CHAN_BASE;

  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255) begin : g_bad_settle
    $error("SETTLE_CYCLES must lie in 1..255");
  end

  // Pin synchronisers. Order: mode, chip select, read, write, lines.
  logic [SYNC_W-1:0] pin_meta_q;
  logic [SYNC_W-1:0] pin_sync_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pin_meta_q <= '1;
      pin_sync_q <= '1;
    end else begin
      pin_meta_q <= {mode_sel_in, chip_sel_n_in, read_n_in, write_n_in,
                     shared_data_lines_in};
      pin_sync_q <= pin_meta_q;
    end
  end

  logic                        par_mode;
  logic                        cs_n_s;
  logic                        rd_n_s;
  logic                        wr_n_s;
  logic [ahi_pkg::LINES_W-1:0] lines_s;
  logic                        tfs_n_s;
  logic                        rfs_n_s;

  assign {par_mode, cs_n_s, rd_n_s, wr_n_s, lines_s} = pin_sync_q;
  assign tfs_n_s = lines_s[ahi_pkg::LINE_TFS];
  assign rfs_n_s = lines_s[ahi_pkg::LINE_RFS];

  ahi_pkg::ahi_ctrl_t ctrl_q;
  ahi_pkg::ahi_ctrl_t wr_lat_q;
  logic               rd_act;
  logic               wr_act;
  logic               wr_act_q;
  logic               wr_done;

  assign rd_act  = par_mode && !cs_n_s && !rd_n_s;
  assign wr_act  = par_mode && !cs_n_s && !wr_n_s;
  assign wr_done = wr_act_q && !wr_act;

  // Result coding shared by both modes.
  logic [ahi_pkg::RES_W-1:0] coded;

  always_comb begin
    coded = result_in;
    if (ctrl_q.format) begin
      coded[ahi_pkg::RES_W-1] = ~result_in[ahi_pkg::RES_W-1];
    end
  end

  // Parallel read path. The enable follows the synchronised strobes, so
  // the lines turn on and off two clocks after the pins move.
  logic [ahi_pkg::LINES_W-1:0] par_data_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      par_data_q <= 12'h000;
    end else begin
      par_data_q <= coded;
    end
  end

  logic serial_dout;

  always_comb begin
    shared_data_lines_out    = 12'h000;
    shared_data_lines_oe_out = 12'h000;
    if (par_mode) begin
      shared_data_lines_out = par_data_q;
      if (rd_act) begin
        shared_data_lines_oe_out = 12'hFFF;
      end
    end else begin
      shared_data_lines_out[ahi_pkg::LINE_DOUT]    = serial_dout;
      shared_data_lines_oe_out[ahi_pkg::LINE_DOUT] = 1'b1;
    end
  end

  // Parallel write capture: the last levels seen while the strobe is low.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wr_act_q <= 1'b0;
      wr_lat_q <= ahi_pkg::CTRL_RESET;
    end else begin
      wr_act_q <= wr_act;
      if (wr_act) begin
        wr_lat_q <= {lines_s[ahi_pkg::LINE_CHAN_MSB],
                     lines_s[ahi_pkg::LINE_CHAN_MID],
                     lines_s[ahi_pkg::LINE_CHAN_LSB],
                     lines_s[ahi_pkg::LINE_SOFT_CONVERT_BIT],
                     lines_s[ahi_pkg::LINE_STBY],
                     lines_s[ahi_pkg::LINE_FORMAT]};
      end
    end
  end

  // Serial word crossing. The word is held still in the link domain until
  // the next full frame, so only the toggle needs synchronising.
  ahi_pkg::ahi_ctrl_t          rx_word;
  logic                        rx_toggle;
  logic                        tog_meta_q;
  logic                        tog_sync_q;
  logic                        tog_seen_q;
  logic                        ser_load;
  logic [ahi_pkg::FRAME_W-1:0] tx_frame_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tog_meta_q <= 1'b0;
      tog_sync_q <= 1'b0;
      tog_seen_q <= 1'b0;
    end else begin
      tog_meta_q <= rx_toggle;
      tog_sync_q <= tog_meta_q;
      tog_seen_q <= tog_sync_q;
    end
  end

  assign ser_load = !par_mode && (tog_sync_q != tog_seen_q);

  // Short transmit frame detection on the synchronised sync.
  logic tfs_q;
  logic got_word_q;
  logic short_frame;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tfs_q      <= 1'b1;
      got_word_q <= 1'b0;
    end else begin
      // Parallel mode holds the history high, so a mode change never looks like a cut frame.
      tfs_q <= tfs_n_s || par_mode;
      if (tfs_q && !tfs_n_s) begin
        got_word_q <= 1'b0;
      end else if (ser_load) begin
        got_word_q <= 1'b1;
      end
    end
  end

  assign short_frame = !par_mode && !tfs_q && tfs_n_s && !got_word_q && !ser_load;

  // Control word.
  logic wrote_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_q  <= ahi_pkg::CTRL_RESET;
      wrote_q <= 1'b0;
    end else if (wr_done) begin
      ctrl_q  <= wr_lat_q;
      wrote_q <= 1'b1;
    end else if (ser_load) begin
      ctrl_q  <= rx_word;
      wrote_q <= 1'b1;
    end
  end

  // Settling pulse, restarted by every write and by a short frame while the soft convert bit is set.
  logic [7:0] settle_q;
  logic       settle_start;

  assign settle_start = wr_done || ser_load || (short_frame && ctrl_q.soft_convert_bit);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      settle_q          <= 8'h00;
      convert_start_out <= 1'b0;
    end else begin
      convert_start_out <= 1'b0;
      if (settle_start) begin
        settle_q <= 8'(SETTLE_CYCLES);
      end else if (settle_q != 8'h00) begin
        settle_q <= settle_q - 8'h01;
        if (settle_q == 8'h01) begin
          convert_start_out <= ctrl_q.soft_convert_bit;
        end
      end
    end
  end

  // Frame word only changes while no receive frame is open.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tx_frame_q  <= 16'h0000;
      channel_out <= CHAN_INIT;
      standby_out <= 1'b0;
    end else begin
      if (rfs_n_s) begin
        tx_frame_q <= {ctrl_q.format, ctrl_q.chan_sel_msb,
                       ctrl_q.chan_sel_mid, ctrl_q.chan_sel_lsb, coded};
      end
      channel_out <= {1'b0, ctrl_q.chan_sel_msb, ctrl_q.chan_sel_mid,
                      ctrl_q.chan_sel_lsb} + ahi_pkg::CHAN_BASE;
      standby_out <= ctrl_q.soft_standby_bit;
    end
  end

  assign control_word_out = ctrl_q;

  // The link clock enters on its own port; it is the wire of line five.
  ahi_serial_link u_link (
    .link_clk_in        (link_clk_in),
    .reset_in           (reset_in),
    .tx_frame_sync_n_in (shared_data_lines_in[ahi_pkg::LINE_TFS]),
    .rx_frame_sync_n_in (shared_data_lines_in[ahi_pkg::LINE_RFS]),
    .serial_din_in      (shared_data_lines_in[ahi_pkg::LINE_DIN]),
    .frame_in           (tx_frame_q),
    .rx_word_out        (rx_word),
    .rx_toggle_out      (rx_toggle),
    .serial_dout_out    (serial_dout)
  );

  drive_gate_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (par_mode && !rd_act) |-> shared_data_lines_oe_out == 12'h000)
    else $error("data lines driven outside a read");

  read_drive_a: assert property (@(posedge clk_in) disable iff (reset_in)
    rd_act |-> shared_data_lines_oe_out == 12'hFFF)
    else $error("data lines not driven during a read");

  read_lsb_a: assert property (@(posedge clk_in) disable iff (reset_in)
    rd_act |=> (!rd_act || shared_data_lines_out[0] == $past(result_in[0])))
    else $error("result lsb not on line zero");

  read_msb_a: assert property (@(posedge clk_in) disable iff (reset_in)
    rd_act |=> (!rd_act ||
      shared_data_lines_out[11] == ($past(result_in[11]) ^ $past(ctrl_q.format))))
    else $error("result msb not on line eleven");

  read_coding_a: assert property (@(posedge clk_in) disable iff (reset_in)
    $stable(ctrl_q) |=> par_data_q ==
      {$past(result_in[11]) ^ $past(ctrl_q.format), $past(result_in[10:0])})
    else $error("parallel result coding wrong");

  serial_drive_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !par_mode |-> shared_data_lines_oe_out == 12'h040)
    else $error("serial mode drives a line other than data out");

  write_capture_a: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_done |=> ctrl_q == $past(wr_lat_q))
    else $error("parallel write not loaded");

  standby_follow_a: assert property (@(posedge clk_in) disable iff (reset_in)
    1'b1 |=> standby_out == $past(ctrl_q.soft_standby_bit))
    else $error("standby output does not follow the control word");

  ctrl_reset_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !wrote_q |-> ctrl_q == ahi_pkg::CTRL_RESET)
    else $error("control word not zero after reset");

  serial_load_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (ser_load && !wr_done) |=> ctrl_q == $past(rx_word))
    else $error("serial control word not loaded");

  short_frame_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (short_frame && !wr_done) |=> $stable(ctrl_q))
    else $error("short frame changed the control word");

  settle_load_a: assert property (@(posedge clk_in) disable iff (reset_in)
    settle_start |=> settle_q == 8'(SETTLE_CYCLES))
    else $error("settling pulse not restarted");

  settle_conv_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (settle_q == 8'h01 && !settle_start)
      |=> convert_start_out == $past(ctrl_q.soft_convert_bit))
    else $error("conversion start not at settling end");

  conv_origin_a: assert property (@(posedge clk_in) disable iff (reset_in)
    convert_start_out |-> ($past(settle_q) == 8'h01 && $past(ctrl_q.soft_convert_bit)))
    else $error("conversion started outside a settling end");

  conv_pulse_a: assert property (@(posedge clk_in) disable iff (reset_in)
    convert_start_out |=> !convert_start_out)
    else $error("conversion start longer than one cycle");

  channel_num_a: assert property (@(posedge clk_in) disable iff (reset_in)
    $stable(ctrl_q) |=> channel_out == 4'({1'b0, $past(ctrl_q[5:3])}) + 4'h1)
    else $error("channel number wrong");

  channel_range_a: assert property (@(posedge clk_in) disable iff (reset_in)
    channel_out >= 4'h1 && channel_out <= 4'h8)
    else $error("channel number out of range");

  frame_freeze_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !rfs_n_s |=> $stable(tx_frame_q))
    else $error("serial frame word changed during a read frame");

  frame_layout_a: assert property (@(posedge clk_in) disable iff (reset_in)
    rfs_n_s |=> tx_frame_q == {$past(ctrl_q.format), $past(ctrl_q[5:3]),
      $past(result_in[11]) ^ $past(ctrl_q.format), $past(result_in[10:0])})
    else $error("serial frame word laid out wrongly");

endmodule
`default_nettype wire

// ===== sim/ahi_host_model.sv
// Host side model: strobes, shared line drive and the serial link clock.
`timescale 1ns/100ps
`default_nettype none
module ahi_host_model (
  input  wire logic        clk_in,
  input  wire logic [11:0] dev_lines_in,
  input  wire logic [11:0] dev_oe_in,
  output logic             mode_sel_out,
  output logic             chip_sel_n_out,
  output logic             read_n_out,
  output logic             write_n_out,
  output logic             link_clk_out,
  output logic [11:0]      lines_out
);
  logic [11:0] drv;
  logic [11:0] drv_oe;

  // A released line shows the inverse of the last host value, so stale data never matches.
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      lines_out[i] = dev_oe_in[i] ? dev_lines_in[i] : (drv_oe[i] ? drv[i] : ~drv[i]);
    end
    if (!mode_sel_out) begin
      lines_out[5] = link_clk_out;
    end
  end

  initial begin
    mode_sel_out = 1'b1;
    chip_sel_n_out = 1'b1;
    read_n_out = 1'b1;
    write_n_out = 1'b1;
    link_clk_out = 1'b0;
    drv = 12'h000;
    drv_oe = 12'h000;
  end

  task automatic set_mode(input logic m);
    @(posedge clk_in);
    mode_sel_out <= m;
    drv_oe <= m ? 12'h000 : 12'h01f;
    drv <= 12'h00c;
    repeat (8) @(posedge clk_in);
  endtask

  task automatic pwrite(input logic [5:0] c);
    @(posedge clk_in);
    chip_sel_n_out <= 1'b0;
    write_n_out <= 1'b0;
    drv_oe <= 12'hfff;
    drv <= {c[0], c[1], c[2], c[3], c[4], c[5], 6'($urandom)};
    repeat (5) @(posedge clk_in);
    chip_sel_n_out <= 1'b1;
    write_n_out <= 1'b1;
    repeat (2) @(posedge clk_in);
    drv_oe <= 12'h000;
    repeat (6) @(posedge clk_in);
  endtask

  task automatic pread();
    @(posedge clk_in);
    chip_sel_n_out <= 1'b0;
    read_n_out <= 1'b0;
    repeat (6) @(posedge clk_in);
    read_n_out <= 1'b1;
    chip_sel_n_out <= 1'b1;
    repeat (5) @(posedge clk_in);
  endtask

  // Both syncs fall together so one frame writes and reads at once.
  task automatic sframe(input logic [5:0] w, input int n, output logic [15:0] rd);
    @(posedge clk_in);
    drv[3:2] <= 2'h0;
    #20;
    for (int k = 0; k < n; k++) begin
      link_clk_out = 1'b1;
      drv[4] = (k < 6) ? w[5 - k] : 1'($urandom);
      #6;
      if (k < 16) begin
        rd[15 - k] = dev_lines_in[6];
      end
      link_clk_out = 1'b0;
      #6;
    end
    drv[3:2] = 2'h3;
    repeat (10) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// ===== sim/ahi_host_interface_tb_top.sv
// Self-checking bench of the converter host interface.
`timescale 1ns/100ps
`default_nettype none
module ahi_host_interface_tb_top;
  logic               clk_in;
  logic               reset_in;
  logic [11:0]        result;
  logic               mode;
  logic               cs_n;
  logic               rd_n;
  logic               wr_n;
  logic               lclk;
  logic [11:0]        lines_in;
  logic [11:0]        lines_out;
  logic [11:0]        oe;
  logic               conv;
  logic               stby;
  logic [3:0]         chan;
  ahi_pkg::ahi_ctrl_t cw;
  logic [5:0]         cw_prev;
  logic [11:0]        oe_prev;
  logic [5:0]         ctrl_q[$];
  logic [11:0]        rd_q[$];
  int                 n_mismatch = 0;
  int                 comparisons = 0;
  int                 conv_n = 0;
  int                 exp_conv = 0;
  int                 cyc = 0;

  ahi_host_interface #(.SETTLE_CYCLES(2)) ahi_host_interface_inst (
    .clk_in(clk_in), .reset_in(reset_in), .mode_sel_in(mode), .chip_sel_n_in(cs_n),
    .read_n_in(rd_n), .write_n_in(wr_n), .link_clk_in(lclk),
    .shared_data_lines_in(lines_in), .shared_data_lines_out(lines_out),
    .shared_data_lines_oe_out(oe), .result_in(result), .convert_start_out(conv),
    .standby_out(stby), .channel_out(chan), .control_word_out(cw)
  );

  ahi_host_model ahi_host_model_inst (
    .clk_in(clk_in), .dev_lines_in(lines_out), .dev_oe_in(oe), .mode_sel_out(mode),
    .chip_sel_n_out(cs_n), .read_n_out(rd_n), .write_n_out(wr_n),
    .link_clk_out(lclk), .lines_out(lines_in)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic [11:0] code(input logic [11:0] r, input logic f);
    return f ? {~r[11], r[10:0]} : r;
  endfunction

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // Watcher: every control change and every read takes the oldest note.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    cw_prev <= cw;
    oe_prev <= oe;
    if (conv === 1'b1) begin
      conv_n <= conv_n + 1;
    end
    if (!reset_in && cw !== cw_prev) begin
      check(cw, ctrl_q.pop_front());
    end
    if (oe === 12'hfff && oe_prev !== 12'hfff) begin
      check(lines_out, rd_q.pop_front());
    end
    if (cyc == 2000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    logic [15:0] rd;
    logic [5:0]  w;
    logic [5:0]  cur;
    int          n;
    reset_in = 1'b1;
    result = 12'h000;
    void'($urandom(38162));
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    check(cw, 6'h00);
    check(chan, 4'h1);
    cur = 6'h00;
    for (int i = 0; i < 6; i++) begin
      w = 6'($urandom);
      w[0] = i[0];
      if (w != cur) ctrl_q.push_back(w);
      if (w[2]) exp_conv++;
      ahi_host_model_inst.pwrite(w);
      cur = w;
      check(chan, {1'b0, w[5:3]} + 4'h1);
      check(stby, w[1]);
      result <= 12'($urandom);
      @(posedge clk_in);
      rd_q.push_back(code(result, w[0]));
      ahi_host_model_inst.pread();
      check(oe, 12'h000);
    end
    check(conv_n, exp_conv);
    ahi_host_model_inst.set_mode(1'b0);
    check(oe, 12'h040);
    for (int i = 0; i < 6; i++) begin
      w = 6'($urandom);
      w[0] = i[0];
      n = (i == 2) ? 3 : 16 + i;
      result <= 12'($urandom);
      repeat (4) @(posedge clk_in);
      if (n >= 6 && w != cur) ctrl_q.push_back(w);
      if ((n >= 6 && w[2]) || (n < 6 && cur[2])) exp_conv++;
      ahi_host_model_inst.sframe(w, n, rd);
      if (n >= 16) begin
        check(rd, {cur[0], cur[5:3], code(result, cur[0])});
      end
      if (n >= 6) cur = w;
      check(cw, cur);
    end
    check(conv_n, exp_conv);
    tally_and_finish();
  end
endmodule
`default_nettype wire
